// File: design/spi_hs_slave.sv
// Device end: handshaking serial slave, full duplex and four-pin half duplex
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "spi_hs_regs.svh"
// Notes on behaviour
// - System clock logic; serial clock times bits
// - Only the master starts, selecting then clocking
// - First byte is command, data bytes follow
// - Transaction ends when select is released
// - Select release anywhere abandons to idle
// - Full duplex: command byte answered with status
// - Write: status per byte, stream while space
// - Full duplex read alternates data and status
// - Three-bit address compared with own address
// - Direction bit one reads, zero writes
// - Transmit empty set when nothing new waits
// - Receive full set while unread data held
// - Acknowledge set only on own address
// - Half duplex: data on shared line, status apart
// - Half duplex write: status during command, stream
// - Half duplex read: slave drives shared line after command
// - Clock idles low; sample falling, launch rising
module spi_hs_slave (
  // System
  input  logic              clk_sys_in,
  input  logic              rst_b_in,
  // Link pins
  spi_link_if.slave         link,
  // Configuration
  input  spi_hs_pkg::addr_t own_addr_in,
  input  logic              half_duplex_in,
  // Transmit side
  input  spi_hs_pkg::byte_t tx_data_in,
  input  logic              tx_load_in,
  output logic              tx_empty_out,
  // Receive side
  input  logic              rx_read_in,
  output spi_hs_pkg::byte_t rx_data_out,
  output logic              rx_full_out,
  output logic              rx_overrun_out,
  // Activity
  output logic              busy_out
);
  import spi_hs_pkg::*;

  logic [2:0]   pins_s;
  logic         sclk_s;
  logic         ss_n_s;
  logic         mosi_s;
  logic         sclk_d;
  logic         sel_d;
  logic         selected;
  logic         sel_start;
  logic         rise;
  logic         fall;
  logic         byte_done;
  slave_phase_e phase;
  slave_phase_e next_phase;
  logic [2:0]   bit_cnt;
  byte_t        rx_shift;
  byte_t        rx_byte;
  byte_t        tx_shift;
  byte_t        dat_shift;
  byte_t        next_tx;
  byte_t        tx_buf;
  logic         ack;
  logic         next_ack;
  logic         addr_match;
  logic         store;
  logic         take_tx;

  function automatic byte_t make_status(input logic tx_buffer_empty_flag, input logic rx_buffer_full_flag, input logic ak);
    byte_t s;
    s = `BYTE_ZERO;
    s[`STAT_TXE_BIT] = tx_buffer_empty_flag;
    s[`STAT_RXF_BIT] = rx_buffer_full_flag;
    s[`STAT_ACK_BIT] = ak;
    return s;
  endfunction : make_status

  // Pins from the master pass two flops before any logic
  sync2 #(
    .WIDTH (3)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .d_in       ({link.sclk, link.ss_n, link.mosi_line}),
    .q_out      (pins_s)
  );

  assign sclk_s    = pins_s[2];
  assign ss_n_s    = pins_s[1];
  assign mosi_s    = pins_s[0];
  assign selected  = !ss_n_s;
  assign sel_start = selected && !sel_d;
  assign rise      = selected && sclk_s && !sclk_d;
  assign fall      = selected && !sclk_s && sclk_d;
  assign byte_done = fall && (bit_cnt == `BIT_LAST);
  assign rx_byte   = {rx_shift[6:0], mosi_s};

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sclk_d <= 1'b0;
      sel_d  <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      sel_d  <= selected;
    end
  end

  // Command decode
  assign addr_match = (rx_byte[`CMD_ADDR_MSB:`CMD_ADDR_LSB] == own_addr_in);

  always_comb begin
    next_phase = phase;
    next_ack   = ack;
    case (phase)
      PH_CMD: begin
        next_ack = addr_match;
        if (!addr_match) begin
          next_phase = PH_IGNORE;
        end else if (rx_byte[`CMD_DIR_BIT]) begin
          next_phase = half_duplex_in ? PH_HD_READ : PH_RD_DATA;
        end else begin
          next_phase = PH_WRITE;
        end
      end
      PH_RD_DATA: next_phase = PH_RD_STAT;
      PH_RD_STAT: next_phase = PH_RD_DATA;
      default:    next_phase = phase;
    endcase
  end

  // Full duplex read data slot carries the buffer, every other slot status
  always_comb begin
    if (next_phase == PH_RD_DATA) begin
      next_tx = tx_buf;
    end else begin
      // A byte stored at this edge already counts as unread
      next_tx = make_status(tx_empty_out, rx_full_out || store, next_ack);
    end
  end

  assign take_tx = byte_done && ((next_phase == PH_RD_DATA) || (next_phase == PH_HD_READ));
  assign store   = byte_done && (phase == PH_WRITE);

  // Byte framing and shifting
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase     <= PH_IDLE;
      bit_cnt   <= `BIT_FIRST;
      rx_shift  <= `BYTE_ZERO;
      tx_shift  <= `BYTE_ZERO;
      dat_shift <= `BYTE_ZERO;
      ack       <= 1'b0;
    end else if (!selected) begin
      // Mid-byte release drops the partial byte
      phase   <= PH_IDLE;
      bit_cnt <= `BIT_FIRST;
      ack     <= 1'b0;
    end else if (sel_start) begin
      phase    <= PH_CMD;
      bit_cnt  <= `BIT_FIRST;
      ack      <= 1'b0;
      tx_shift <= make_status(tx_empty_out, rx_full_out, 1'b0);
    end else if (rise) begin
      tx_shift  <= {tx_shift[6:0], 1'b0};
      dat_shift <= {dat_shift[6:0], 1'b0};
    end else if (fall) begin
      rx_shift <= rx_byte;
      bit_cnt  <= bit_cnt + 3'h1;
      if (byte_done) begin
        phase     <= next_phase;
        ack       <= next_ack;
        tx_shift  <= next_tx;
        dat_shift <= tx_buf;
      end
    end
  end

  // Pin drivers launch on the rising edge
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link.s_miso <= 1'b1;
      link.s_mosi <= 1'b1;
    end else if (rise) begin
      link.s_miso <= tx_shift[7];
      link.s_mosi <= dat_shift[7];
    end
  end

  // Unaddressed slaves free the shared lines once the command byte shows a foreign address
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link.s_miso_oe_n <= 1'b1;
      link.s_mosi_oe_n <= 1'b1;
    end else begin
      link.s_miso_oe_n <= !(selected && (phase != PH_IDLE) && (phase != PH_IGNORE));
      // Drive only after the master has released the line
      link.s_mosi_oe_n <= !(selected && (phase == PH_HD_READ));
    end
  end

  // Receive buffer; a byte arriving while full is dropped even if a read clears it in the same cycle
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_full_out    <= 1'b0;
      rx_data_out    <= `BYTE_ZERO;
      rx_overrun_out <= 1'b0;
    end else begin
      rx_overrun_out <= store && rx_full_out;
      if (store && !rx_full_out) begin
        rx_full_out <= 1'b1;
        rx_data_out <= rx_byte;
      end else if (rx_read_in) begin
        rx_full_out <= 1'b0;
      end
    end
  end

  // Transmit buffer; a fresh load wins over a simultaneous send
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_empty_out <= 1'b1;
      tx_buf       <= `BYTE_ZERO;
    end else if (tx_load_in) begin
      tx_empty_out <= 1'b0;
      tx_buf       <= tx_data_in;
    end else if (take_tx) begin
      tx_empty_out <= 1'b1;
    end
  end

  assign busy_out = (phase != PH_IDLE);
endmodule : spi_hs_slave

// File: design/spi_hs_regs.svh
// Constants for the handshaking serial slave link and its controller
`ifndef SPI_HS_REGS_SVH
`define SPI_HS_REGS_SVH

// Command byte layout, most significant bit first on the wire
`define CMD_ADDR_MSB    7
`define CMD_ADDR_LSB    5
`define CMD_DIR_BIT     4
// Status byte layout, low bits read as zero
`define STAT_TXE_BIT    7
`define STAT_RXF_BIT    6
`define STAT_ACK_BIT    5
`define BYTE_ZERO       8'h00
`define BIT_LAST        3'h7
`define BIT_FIRST       3'h0
// Link clock made by the controller
`define CLK_PERIOD_NS   4
`define SCLK_HALF_NS    32
// Controller register byte offsets
`define REG_CTRL        5'h00
`define REG_DATA        5'h04
`define REG_STATUS      5'h08
`define REG_IRQ_STAT    5'h0C
`define REG_IRQ_MASK    5'h10
// Control register fields
`define CTRL_START_BIT  0
`define CTRL_END_BIT    1
`define CTRL_DIR_BIT    2
`define CTRL_HD_BIT     3
`define CTRL_ADDR_LSB   4
`define CTRL_ADDR_MSB   6
`define CTRL_BUSY_BIT   8
`define CTRL_SEL_BIT    9
// Interrupt fields
`define IRQ_DONE_BIT    0
`define IRQ_REFUSED_BIT 1
`define IRQ_W           2
`define IRQ_ZERO        2'h0
`define WORD_ZERO       32'h0000_0000

`endif

// File: design/spi_hs_pkg.sv
// Types shared by both ends of the handshaking serial link
package spi_hs_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] addr_t;
  typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_WRITE, PH_RD_DATA, PH_RD_STAT, PH_HD_READ, PH_IGNORE} slave_phase_e;
  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_HOLD} host_state_e;
endpackage : spi_hs_pkg

// File: design/spi_link_if.sv
// Four-wire link with a shared two-way data-in line
`timescale 1ns/1ns
interface spi_link_if;
  logic sclk;
  logic ss_n;
  logic m_mosi;
  logic m_mosi_oe_n;
  logic s_mosi;
  logic s_mosi_oe_n;
  logic s_miso;
  logic s_miso_oe_n;
  logic mosi_line;
  logic miso_line;

  // Undriven lines float high as with a pull-up
  assign mosi_line = !m_mosi_oe_n ? m_mosi : (!s_mosi_oe_n ? s_mosi : 1'b1);
  assign miso_line = !s_miso_oe_n ? s_miso : 1'b1;

  modport master (output sclk, output ss_n, output m_mosi, output m_mosi_oe_n,
                  input mosi_line, input miso_line);
  modport slave  (input sclk, input ss_n, output s_mosi, output s_mosi_oe_n,
                  output s_miso, output s_miso_oe_n, input mosi_line);
endinterface : spi_link_if

// File: design/sync2.sv
// Two-stage synchroniser for pins from outside the system clock domain
`timescale 1ns/1ns
module sync2 #(
  parameter int WIDTH = 1
) (
  // System
  input  logic             clk_sys_in,
  input  logic             rst_b_in,
  // Pins
  input  logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta  <= '1;
      q_out <= '1;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule : sync2

// File: design/spi_hs_master.sv
// Controller end: serial master steered by software over Avalon-MM
`timescale 1ns/1ns
`include "spi_hs_regs.svh"
module spi_hs_master #(
  parameter int HALF_CYC = (`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // System
  input  logic        clk_sys_in,
  input  logic        rst_b_in,
  // Avalon-MM slave
  input  logic [4:0]  avs_address_in,
  input  logic        avs_read_in,
  input  logic        avs_write_in,
  input  logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic        avs_waitrequest_out,
  // Interrupt
  output logic        irq_out,
  // Link pins
  spi_link_if.master  link
);
  import spi_hs_pkg::*;

  host_state_e          state;
  logic [1:0]           lines_s;
  logic                 req;
  logic                 ack_q;
  logic                 stall;
  logic                 acc_wr;
  logic                 acc_rd;
  logic [7:0]           div;
  logic [2:0]           bit_cnt;
  logic                 is_cmd;
  logic                 dir_rd;
  logic                 hd;
  addr_t                addr;
  byte_t                tx_sh;
  byte_t                rx_sh;
  byte_t                st_sh;
  byte_t                rx_q;
  byte_t                st_q;
  logic                 refuse;
  logic [`IRQ_W-1:0]    irq_stat;
  logic [`IRQ_W-1:0]    irq_mask;
  logic [`IRQ_W-1:0]    irq_set;
  logic [`IRQ_W-1:0]    irq_clr;
  logic                 last_fall;
  logic                 after_cmd;

  sync2 #(
    .WIDTH (2)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .d_in       ({link.mosi_line, link.miso_line}),
    .q_out      (lines_s)
  );

  // One wait state per access; writes that start shifting stall while busy
  assign req    = avs_read_in || avs_write_in;
  assign stall  = avs_write_in && (state == H_SHIFT) &&
                  ((avs_address_in == `REG_CTRL) || (avs_address_in == `REG_DATA));
  assign avs_waitrequest_out = req && !ack_q;
  assign acc_wr = avs_write_in && ack_q;
  assign acc_rd = avs_read_in && ack_q;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_q            <= 1'b0;
      avs_readdata_out <= `WORD_ZERO;
    end else begin
      ack_q <= req && !ack_q && !stall;
      if (avs_read_in && !ack_q) begin
        case (avs_address_in)
          `REG_CTRL:     avs_readdata_out <= {22'h00_0000, !link.ss_n, state == H_SHIFT,
                                              1'b0, addr, hd, dir_rd, 2'h0};
          `REG_DATA:     avs_readdata_out <= {24'h00_0000, rx_q};
          `REG_STATUS:   avs_readdata_out <= {24'h00_0000, st_q};
          `REG_IRQ_STAT: avs_readdata_out <= {30'h0000_0000, irq_stat};
          `REG_IRQ_MASK: avs_readdata_out <= {30'h0000_0000, irq_mask};
          default:       avs_readdata_out <= `WORD_ZERO;
        endcase
      end
    end
  end

  // Writes need room; status sent during the command cannot carry an acknowledge yet
  assign refuse    = !dir_rd && (st_q[`STAT_RXF_BIT] || (!st_q[`STAT_ACK_BIT] && !after_cmd));
  assign last_fall = (state == H_SHIFT) && (div == 8'(HALF_CYC - 1)) && link.sclk && (bit_cnt == `BIT_LAST);

  // Transaction sequencing and clock divider
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state            <= H_IDLE;
      link.ss_n        <= 1'b1;
      link.sclk        <= 1'b0;
      link.m_mosi      <= 1'b1;
      link.m_mosi_oe_n <= 1'b1;
      div              <= 8'h00;
      bit_cnt          <= `BIT_FIRST;
      is_cmd           <= 1'b0;
      after_cmd        <= 1'b0;
      dir_rd           <= 1'b0;
      hd               <= 1'b0;
      addr             <= 3'h0;
      tx_sh            <= `BYTE_ZERO;
      rx_sh            <= `BYTE_ZERO;
      st_sh            <= `BYTE_ZERO;
      rx_q             <= `BYTE_ZERO;
      st_q             <= `BYTE_ZERO;
    end else begin
      case (state)
        H_IDLE: begin
          if (acc_wr && (avs_address_in == `REG_CTRL) && avs_writedata_in[`CTRL_START_BIT]) begin
            dir_rd           <= avs_writedata_in[`CTRL_DIR_BIT];
            hd               <= avs_writedata_in[`CTRL_HD_BIT];
            addr             <= avs_writedata_in[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB];
            tx_sh            <= {avs_writedata_in[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB],
                                 avs_writedata_in[`CTRL_DIR_BIT], 4'h0};
            link.ss_n        <= 1'b0;
            link.m_mosi_oe_n <= 1'b0;
            is_cmd           <= 1'b1;
            div              <= 8'h00;
            bit_cnt          <= `BIT_FIRST;
            state            <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (div == 8'(HALF_CYC - 1)) begin
            div <= 8'h00;
            if (!link.sclk) begin
              link.sclk   <= 1'b1;
              link.m_mosi <= tx_sh[7];
              tx_sh       <= {tx_sh[6:0], 1'b0};
            end else begin
              link.sclk <= 1'b0;
              rx_sh     <= {rx_sh[6:0], hd ? lines_s[1] : lines_s[0]};
              st_sh     <= {st_sh[6:0], lines_s[0]};
              bit_cnt   <= bit_cnt + 3'h1;
              if (bit_cnt == `BIT_LAST) begin
                rx_q   <= {rx_sh[6:0], hd ? lines_s[1] : lines_s[0]};
                st_q   <= {st_sh[6:0], lines_s[0]};
                after_cmd <= is_cmd;
                is_cmd <= 1'b0;
                state  <= H_HOLD;
                if (is_cmd && hd && dir_rd) begin
                  link.m_mosi_oe_n <= 1'b1;
                end
              end
            end
          end else begin
            div <= div + 8'h01;
          end
        end
        H_HOLD: begin
          if (acc_wr && (avs_address_in == `REG_CTRL) && avs_writedata_in[`CTRL_END_BIT]) begin
            link.ss_n        <= 1'b1;
            link.m_mosi_oe_n <= 1'b1;
            state            <= H_IDLE;
          end else if (acc_wr && (avs_address_in == `REG_DATA) && !refuse) begin
            tx_sh   <= avs_writedata_in[7:0];
            div     <= 8'h00;
            bit_cnt <= `BIT_FIRST;
            state   <= H_SHIFT;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // Sticky events; read clears only the bits that were returned
  always_comb begin
    irq_set                   = `IRQ_ZERO;
    irq_set[`IRQ_DONE_BIT]    = last_fall;
    irq_set[`IRQ_REFUSED_BIT] = acc_wr && (state == H_HOLD) && (avs_address_in == `REG_DATA) && refuse;
    irq_clr                   = (acc_rd && (avs_address_in == `REG_IRQ_STAT)) ?
                                avs_readdata_out[`IRQ_W-1:0] : `IRQ_ZERO;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_stat <= `IRQ_ZERO;
      irq_mask <= `IRQ_ZERO;
      irq_out  <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      if (acc_wr && (avs_address_in == `REG_IRQ_MASK)) begin
        irq_mask <= avs_writedata_in[`IRQ_W-1:0];
      end
      irq_out <= |(irq_stat & irq_mask);
    end
  end
endmodule : spi_hs_master

// File: dv/spi_hs_sva.sv
// Timing checks on the serial link between controller and slave
`timescale 1ns/1ns
module spi_hs_sva #(
  parameter int HALF_CYC = 8
) (
  // System
  input logic clk_sys_in,
  input logic rst_b_in,
  // Link
  input logic sclk,
  input logic ss_n,
  input logic m_mosi,
  input logic m_mosi_oe_n,
  input logic s_mosi,
  input logic s_mosi_oe_n,
  input logic s_miso,
  input logic s_miso_oe_n,
  input logic mosi_line,
  input logic miso_line
);
  logic [7:0] high_run;

  // Length of the current high phase of the link clock
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      high_run <= 8'h00;
    end else if (!sclk) begin
      high_run <= 8'h00;
    end else begin
      high_run <= high_run + 8'h01;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);

  a_sclk_idle_low: assert property (ss_n |-> !sclk)
    else $error("link clock not low while deselected");
  a_sclk_high_len: assert property ($fell(sclk) |-> high_run == 8'(HALF_CYC))
    else $error("link clock high phase of wrong length");
  a_mosi_no_fight: assert property (!(!m_mosi_oe_n && !s_mosi_oe_n))
    else $error("both ends drive the shared line");
  a_master_launch_rise: assert property (sclk && $past(sclk) && !m_mosi_oe_n |-> $stable(m_mosi))
    else $error("master data moved while clock high");
  a_miso_settled_fall: assert property ($fell(sclk) |-> miso_line == $past(miso_line, 2))
    else $error("return line not settled at sampling edge");
  a_mosi_settled_fall: assert property ($fell(sclk) && $stable(m_mosi_oe_n) |-> mosi_line == $past(mosi_line, 2))
    else $error("shared line not settled at sampling edge");
  a_deselect_release: assert property ($rose(ss_n) |-> ##[1:6] (s_miso_oe_n && s_mosi_oe_n))
    else $error("slave still drives after deselect");
  a_end_clock_quiet: assert property ($rose(ss_n) |-> !sclk && !$past(sclk, 4))
    else $error("select raised too close to a clock edge");
  a_cmd_from_master: assert property ($fell(ss_n) |-> !m_mosi_oe_n && s_mosi_oe_n)
    else $error("command byte not driven by master");

  c_frame_end: cover property ($rose(ss_n));
  c_turnaround: cover property ($fell(s_mosi_oe_n));
  c_mismatch_release: cover property ($rose(s_miso_oe_n) && !ss_n);
endmodule : spi_hs_sva

// File: dv/spi_slave_status_handshake_bench.sv
// Self-checking bench joining controller and slave over the serial link
`timescale 1ns/1ns
`include "spi_hs_regs.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module spi_slave_status_handshake_bench;
  import spi_hs_pkg::*;
  localparam int HALF = 8;
  logic              clk_sys_in = 1'b0;
  logic              rst_b_in = 1'b0;
  logic [4:0]        avs_address = 5'h00;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = 32'h0000_0000;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              irq;
  addr_t             own_addr = 3'h0;
  logic              half_duplex = 1'b0;
  byte_t             tx_data = 8'h00;
  logic              tx_load = 1'b0;
  logic              rx_read = 1'b0;
  byte_t             rx_data;
  logic              rx_full;
  logic              tx_empty;
  logic              busy;
  logic              rx_overrun;
  int                overruns = 0;
  int                err_total = 0;
  int                total_checks = 0;
  logic [31:0]       seed = 32'h0001_6FD3;
  logic [31:0]       q;
  byte_t             st;
  byte_t             rd;
  logic              hd;

  spi_link_if link();
  spi_hs_master #(.HALF_CYC(HALF)) i_spi_hs_master (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata),
    .avs_waitrequest_out(avs_waitrequest), .irq_out(irq), .link(link));
  spi_hs_slave i_spi_hs_slave (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .link(link),
    .own_addr_in(own_addr), .half_duplex_in(half_duplex), .tx_data_in(tx_data), .tx_load_in(tx_load),
    .tx_empty_out(tx_empty), .rx_read_in(rx_read), .rx_data_out(rx_data), .rx_full_out(rx_full),
    .rx_overrun_out(rx_overrun), .busy_out(busy));
  spi_hs_sva #(.HALF_CYC(HALF)) i_spi_hs_sva (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .sclk(link.sclk), .ss_n(link.ss_n), .m_mosi(link.m_mosi), .m_mosi_oe_n(link.m_mosi_oe_n),
    .s_mosi(link.s_mosi), .s_mosi_oe_n(link.s_mosi_oe_n), .s_miso(link.s_miso),
    .s_miso_oe_n(link.s_miso_oe_n), .mosi_line(link.mosi_line), .miso_line(link.miso_line));

  always #2 clk_sys_in = ~clk_sys_in;

  // Dropped bytes: each of the four addressed write scenarios pushes one into a full buffer
  always @(posedge clk_sys_in) begin
    if (rx_overrun === 1'b1) overruns++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic byte_t exp_st(input logic tx_buffer_empty_flag, input logic rx_buffer_full_flag, input logic ack);
    exp_st = `BYTE_ZERO;
    exp_st[`STAT_TXE_BIT] = tx_buffer_empty_flag;
    exp_st[`STAT_RXF_BIT] = rx_buffer_full_flag;
    exp_st[`STAT_ACK_BIT] = ack;
  endfunction : exp_st

  function automatic logic [31:0] ctrl(input logic dir, input logic hdx, input addr_t a);
    ctrl = `WORD_ZERO;
    ctrl[`CTRL_START_BIT] = 1'b1;
    ctrl[`CTRL_DIR_BIT] = dir;
    ctrl[`CTRL_HD_BIT] = hdx;
    ctrl[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB] = a;
  endfunction : ctrl

  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    for (int n = 0; n < 6000; n++) begin
      @(posedge clk_sys_in);
      if (avs_waitrequest === 1'b0) break;
    end
    if (avs_waitrequest !== 1'b0) err_total++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av

  // Waits on the interrupt line, then clears it through the status read
  task automatic wait_done(input logic [1:0] exp);
    for (int n = 0; n < 800 && irq !== 1'b1; n++) @(posedge clk_sys_in);
    `CHK(irq, 1'b1)
    av(1'b0, `REG_IRQ_STAT, `WORD_ZERO);
    `CHK(q[1:0], exp)
    repeat (3) @(posedge clk_sys_in);
    `CHK(irq, 1'b0)
  endtask : wait_done

  task automatic byte_op(input logic [4:0] a, input logic [31:0] w);
    av(1'b1, a, w);
    wait_done(2'h1);
    av(1'b0, `REG_STATUS, `WORD_ZERO);
    st = q[7:0];
    av(1'b0, `REG_DATA, `WORD_ZERO);
    rd = q[7:0];
  endtask : byte_op

  // Stray flags from the end request are cleared without judging them
  task automatic end_sel();
    av(1'b1, `REG_CTRL, 32'h0000_0002);
    repeat (8) @(posedge clk_sys_in);
    `CHK(link.ss_n, 1'b1)
    `CHK(busy, 1'b0)
    av(1'b0, `REG_IRQ_STAT, `WORD_ZERO);
  endtask : end_sel

  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #120000;
    err_total++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    av(1'b1, `REG_IRQ_MASK, 32'h0000_0003);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      hd = i[0];
      own_addr <= seed[2:0];
      half_duplex <= hd;
      byte_op(`REG_CTRL, ctrl(1'b0, hd, seed[2:0]));
      `CHK(st, exp_st(1'b1, 1'b0, 1'b0))
      byte_op(`REG_DATA, {24'h00_0000, seed[15:8]});
      `CHK(st, exp_st(1'b1, 1'b0, 1'b1))
      `CHK(rx_data, seed[15:8])
      `CHK(rx_full, 1'b1)
      byte_op(`REG_DATA, {24'h00_0000, seed[23:16]});
      `CHK(st, exp_st(1'b1, 1'b1, 1'b1))
      `CHK(rx_data, seed[15:8])
      av(1'b1, `REG_DATA, {24'h00_0000, seed[31:24]});
      wait_done(2'h2);
      end_sel();
      @(posedge clk_sys_in) rx_read <= 1'b1;
      @(posedge clk_sys_in) rx_read <= 1'b0;
      @(posedge clk_sys_in);
      `CHK(rx_full, 1'b0)
      tx_data <= seed[31:24];
      tx_load <= 1'b1;
      @(posedge clk_sys_in) tx_load <= 1'b0;
      @(posedge clk_sys_in);
      `CHK(tx_empty, 1'b0)
      byte_op(`REG_CTRL, ctrl(1'b1, hd, seed[2:0]));
      `CHK(st, exp_st(1'b0, 1'b0, 1'b0))
      byte_op(`REG_DATA, `WORD_ZERO);
      `CHK(rd, seed[31:24])
      `CHK(tx_empty, 1'b1)
      av(1'b0, `REG_CTRL, `WORD_ZERO);
      `CHK(q, ctrl(1'b1, hd, seed[2:0]) ^ 32'h0000_0201)
      if (!hd) begin
        byte_op(`REG_DATA, `WORD_ZERO);
        `CHK(st, exp_st(1'b1, 1'b0, 1'b1))
      end else begin
        `CHK(link.m_mosi_oe_n, 1'b1)
      end
      end_sel();
    end
    // Foreign address: status still answers, then the line floats
    own_addr <= 3'h2;
    half_duplex <= 1'b0;
    byte_op(`REG_CTRL, ctrl(1'b1, 1'b0, 3'h5));
    `CHK(st, exp_st(1'b1, 1'b0, 1'b0))
    byte_op(`REG_DATA, `WORD_ZERO);
    `CHK(st, 8'hFF)
    end_sel();
    byte_op(`REG_CTRL, ctrl(1'b0, 1'b0, 3'h5));
    byte_op(`REG_DATA, 32'h0000_005A);
    `CHK(st, 8'hFF)
    av(1'b1, `REG_IRQ_MASK, `WORD_ZERO);
    av(1'b1, `REG_DATA, 32'h0000_00A5);
    repeat (4) @(posedge clk_sys_in);
    `CHK(irq, 1'b0)
    av(1'b1, `REG_IRQ_MASK, 32'h0000_0002);
    wait_done(2'h2);
    `CHK(rx_full, 1'b0)
    end_sel();
    av(1'b0, 5'h14, `WORD_ZERO);
    `CHK(q, `WORD_ZERO)
    av(1'b0, `REG_IRQ_MASK, `WORD_ZERO);
    `CHK(q[1:0], 2'h2)
    `CHK(overruns, 4)
    end_of_test();
  end
endmodule : spi_slave_status_handshake_bench
